/* shared/ilc_pkg.sv */
// Shared classes, latencies and sizes of the issue latency interlock.
`default_nettype none

package ilc_pkg;

    // Producer-consumer classes; the decoder tags each instruction.
    typedef enum logic [3:0] {
        ILC_NONE                   = 4'b0000,
        ILC_LOAD_CLASS             = 4'b0001,
        ILC_STORE_CLASS            = 4'b0010,
        ILC_INT_COND_BRANCH_CLASS  = 4'b0011,
        ILC_FLOAT_COND_BRANCH_CLASS = 4'b0100,
        ILC_JUMP_CLASS             = 4'b0101,
        ILC_INT_ADD_LOGIC_CLASS    = 4'b0110,
        ILC_SHIFT_CMOVE_CLASS      = 4'b0111,
        ILC_INT_COMPARE_CLASS      = 4'b1000,
        ILC_INT_MUL_LONG_CLASS     = 4'b1001,
        ILC_INT_MUL_QUAD_CLASS     = 4'b1010,
        ILC_FLOAT_OPERATE_CLASS    = 4'b1011,
        ILC_FLOAT_DIVIDE_S_CLASS   = 4'b1100,
        ILC_FLOAT_DIVIDE_D_CLASS   = 4'b1101
    } ilc_class_type;

    // Register tags: bit 5 picks the float file, bits 4:0 the number.
    localparam int          REG_W    = 6;
    localparam int          NUM_REGS = 64;
    localparam logic [4:0]  ZERO_REG = 5'h1F;

    // Age counters saturate; every latency below fits under the ceiling.
    localparam int             AGE_W   = 7;
    localparam logic [AGE_W-1:0] AGE_MAX = 7'h7F;
    localparam logic [AGE_W-1:0] AGE_ONE = 7'h01;

    // Producer-consumer latencies in cycles.
    localparam logic [6:0] LAT_ZERO       = 7'h00;
    localparam logic [6:0] LAT_ONE        = 7'h01;
    localparam logic [6:0] LAT_TWO        = 7'h02;
    localparam logic [6:0] LAT_LOAD_HIT   = 7'h03;
    localparam logic [6:0] LAT_MUL_L      = 7'h15;
    localparam logic [6:0] LAT_MUL_L_DATA = 7'h14;
    localparam logic [6:0] LAT_MUL_Q      = 7'h17;
    localparam logic [6:0] LAT_MUL_Q_DATA = 7'h16;
    localparam logic [6:0] LAT_FOP        = 7'h06;
    localparam logic [6:0] LAT_FOP_DATA   = 7'h04;
    localparam logic [6:0] LAT_FLOAT_DIVIDE_CLASS_S     = 7'h22;
    localparam logic [6:0] LAT_FLOAT_DIVIDE_CLASS_S_DATA = 7'h20;
    localparam logic [6:0] LAT_FLOAT_DIVIDE_CLASS_D     = 7'h3F;
    localparam logic [6:0] LAT_FLOAT_DIVIDE_CLASS_D_DATA = 7'h3D;

    // Spacing between independent back-to-back multiplies and divides.
    localparam int         GAP_W      = 6;
    localparam logic [5:0] GAP_MUL_L  = 6'h13;
    localparam logic [5:0] GAP_MUL_Q  = 6'h15;
    localparam logic [5:0] GAP_FLOAT_DIVIDE_CLASS_S = 6'h1E;
    localparam logic [5:0] GAP_FLOAT_DIVIDE_CLASS_D = 6'h3B;

    // Cycles a consumer of class c waits on a producer of class p.
    function automatic logic [6:0] ilc_latency(input ilc_class_type p,
                                               input ilc_class_type c,
                                               input logic          data);
        logic st_data;
        logic far;
        st_data = (c == ILC_STORE_CLASS) && data;
        far = (c == ILC_LOAD_CLASS) || (c == ILC_JUMP_CLASS);
        case (p)
            ILC_LOAD_CLASS, ILC_JUMP_CLASS: ilc_latency = LAT_LOAD_HIT;
            ILC_INT_ADD_LOGIC_CLASS:
                ilc_latency = st_data ? LAT_ZERO :
                              (far || c == ILC_STORE_CLASS) ? LAT_TWO :
                              LAT_ONE;
            ILC_SHIFT_CMOVE_CLASS:
                ilc_latency = st_data ? LAT_ZERO : LAT_TWO;
            ILC_INT_COMPARE_CLASS:
                ilc_latency = st_data ? LAT_ZERO :
                    (c == ILC_INT_COND_BRANCH_CLASS) ? LAT_ONE : LAT_TWO;
            ILC_INT_MUL_LONG_CLASS:
                ilc_latency = st_data ? LAT_MUL_L_DATA : LAT_MUL_L;
            ILC_INT_MUL_QUAD_CLASS:
                ilc_latency = st_data ? LAT_MUL_Q_DATA : LAT_MUL_Q;
            ILC_FLOAT_OPERATE_CLASS:
                ilc_latency = st_data ? LAT_FOP_DATA : LAT_FOP;
            ILC_FLOAT_DIVIDE_S_CLASS:
                ilc_latency = st_data ? LAT_FLOAT_DIVIDE_CLASS_S_DATA : LAT_FLOAT_DIVIDE_CLASS_S;
            ILC_FLOAT_DIVIDE_D_CLASS:
                ilc_latency = st_data ? LAT_FLOAT_DIVIDE_CLASS_D_DATA : LAT_FLOAT_DIVIDE_CLASS_D;
            default: ilc_latency = LAT_ZERO;
        endcase
    endfunction : ilc_latency

    // Cycles until a late-finishing producer has written its register.
    function automatic logic [6:0] ilc_write_done(input ilc_class_type p);
        case (p)
            ILC_LOAD_CLASS:           ilc_write_done = LAT_LOAD_HIT;
            ILC_INT_MUL_LONG_CLASS:   ilc_write_done = LAT_MUL_L;
            ILC_INT_MUL_QUAD_CLASS:   ilc_write_done = LAT_MUL_Q;
            ILC_FLOAT_DIVIDE_S_CLASS: ilc_write_done = LAT_FLOAT_DIVIDE_CLASS_S;
            ILC_FLOAT_DIVIDE_D_CLASS: ilc_write_done = LAT_FLOAT_DIVIDE_CLASS_D;
            default:                  ilc_write_done = LAT_ZERO;
        endcase
    endfunction : ilc_write_done

endpackage : ilc_pkg

`default_nettype wire

/* design/ilc_unit_timer.sv */
// Busy timer for a non-pipelined execution unit.
`default_nettype none

module ilc_unit_timer
    import ilc_pkg::*;
#(
    parameter int W = GAP_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    output logic              busy
);

    logic [W-1:0] count_ff;     // Cycles left before the next start.
    logic [W-1:0] nxt_count;    // Next value of the count.

    // A start loads len minus one, so the next start lands len cycles on.
    always_comb begin
        nxt_count = count_ff;
        if (start) begin
            nxt_count = len - {{(W-1){1'b0}}, 1'b1};
        end else if (count_ff != '0) begin
            nxt_count = count_ff - {{(W-1){1'b0}}, 1'b1};
        end
    end

    // Register the count.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Busy is read combinationally by the issue decision.
    assign busy = (count_ff != '0);

endmodule : ilc_unit_timer

`default_nettype wire

/* design/ilc_issue_interlock.sv */
// Issue stage interlock: class latencies, scoreboard and pair issue.
//
// Functional notes
// - Stall whenever needed; never allow a hazard.
// - Every instruction carries its class at issue.
// - Load producers and prefetch consumers via enables.
// - Branch-to-subroutine is jump class, producer only.
// - Consumer issues N cycles after producer.
// - Shift after add may issue next cycle.
// - Add after shift waits two; one bubble.
// - Add result as store data: dual issue.
// - Store base and store data latencies differ.
// - Load latency assumes hit; miss holds age.
// - Float results never form store base.
// - Multiply spacing: 21/19 long, 23/21 quad; a quad issued beside an older divide gets the 19 gap.
// - Divide spacing: 34/30 single, 63/59 double; a double issued beside an older multiply gets the 30 gap.
// - Impossible class pairs are don't-care.
// - Ordinary writes complete in issue order.
// - Late writers stall later same-register writers.
// - Stalled consumer may pair with second writer.
// - Dual issue only within one aligned quadword.
`default_nettype none

module ilc_issue_interlock
    import ilc_pkg::*;
(
    input  wire logic                SYS_CLK,
    input  wire logic                RST_N,
    input  wire logic                DEC_VALID,
    input  wire logic                DEC_SAME_QUAD,
    input  wire logic                DEC0_VALID,
    input  wire ilc_class_type       DEC0_CLASS,
    input  wire logic [REG_W-1:0]    DEC0_DST,
    input  wire logic                DEC0_DST_EN,
    input  wire logic [REG_W-1:0]    DEC0_SRCA,
    input  wire logic                DEC0_SRCA_EN,
    input  wire logic [REG_W-1:0]    DEC0_SRCB,
    input  wire logic                DEC0_SRCB_EN,
    input  wire logic                DEC1_VALID,
    input  wire ilc_class_type       DEC1_CLASS,
    input  wire logic [REG_W-1:0]    DEC1_DST,
    input  wire logic                DEC1_DST_EN,
    input  wire logic [REG_W-1:0]    DEC1_SRCA,
    input  wire logic                DEC1_SRCA_EN,
    input  wire logic [REG_W-1:0]    DEC1_SRCB,
    input  wire logic                DEC1_SRCB_EN,
    input  wire logic                LOAD_MISS_HOLD,
    output logic                     DEC_READY,
    output logic                     ISSUE0_VALID,
    output ilc_class_type            ISSUE0_CLASS,
    output logic [REG_W-1:0]         ISSUE0_DST,
    output logic                     ISSUE1_VALID,
    output ilc_class_type            ISSUE1_CLASS,
    output logic [REG_W-1:0]         ISSUE1_DST,
    output logic                     ISSUE_STALL
);

    // Held pair at the issue stage; slot 0 is the older instruction.
    logic                 hv_ff   [2];  // Slot holds an instruction.
    ilc_class_type        hcls_ff [2];  // Class of the held instruction.
    logic [REG_W-1:0]     hdst_ff [2];  // Destination register.
    logic                 hde_ff  [2];  // Destination is written.
    logic [REG_W-1:0]     hsa_ff  [2];  // First source (store base).
    logic                 hsae_ff [2];  // First source is read.
    logic [REG_W-1:0]     hsb_ff  [2];  // Second source (store data).
    logic                 hsbe_ff [2];  // Second source is read.
    logic                 quad_ff;      // Both slots share a quadword.
    logic                 nxt_hv  [2];  // Next slot occupancy.

    // Scoreboard: class and age of the last write to each register.
    ilc_class_type        sb_cls_ff [NUM_REGS];
    logic [AGE_W-1:0]     sb_age_ff [NUM_REGS];
    ilc_class_type        nxt_cls   [NUM_REGS];
    logic [AGE_W-1:0]     nxt_age   [NUM_REGS];

    // Registered outputs and their next values.
    logic                 ready_ff;
    logic                 nxt_ready;
    logic                 iv0_ff;
    logic                 iv1_ff;
    ilc_class_type        ic0_ff;
    ilc_class_type        ic1_ff;
    logic [REG_W-1:0]     id0_ff;
    logic [REG_W-1:0]     id1_ff;
    logic                 stall_ff;

    // Issue decision for this cycle and unit timer state.
    logic                 iss [2];      // Slot issues at the coming edge.
    logic                 accept;       // A new pair is taken.
    logic                 mul_busy;     // Multiplier not yet free.
    logic                 div_busy;     // Divider not yet free.
    logic                 mul_start;
    logic                 div_start;
    logic [GAP_W-1:0]     mul_gap;
    logic [GAP_W-1:0]     div_gap;
    ilc_class_type        unit_cls;     // Class starting a unit.

    // True when the named source may be read now.
    function automatic logic src_ok(input logic [REG_W-1:0] r,
                                    input logic            en,
                                    input ilc_class_type   c,
                                    input logic            data);
        // Zero registers and unused operands never wait.
        src_ok = !en || (r[4:0] == ZERO_REG) ||
                 (sb_age_ff[r] >= ilc_latency(sb_cls_ff[r], c, data));
    endfunction : src_ok

    // Class groups sharing one non-pipelined unit.
    function automatic logic is_mul(input ilc_class_type c);
        is_mul = (c == ILC_INT_MUL_LONG_CLASS) ||
                 (c == ILC_INT_MUL_QUAD_CLASS);
    endfunction : is_mul

    function automatic logic is_div(input ilc_class_type c);
        is_div = (c == ILC_FLOAT_DIVIDE_S_CLASS) ||
                 (c == ILC_FLOAT_DIVIDE_D_CLASS);
    endfunction : is_div

    // True when slot s clears scoreboard, ordering and unit checks.
    function automatic logic slot_ok(input int s);
        logic st;
        logic waw;
        logic unit;
        st = (hcls_ff[s] == ILC_STORE_CLASS);
        // Late writers to the same register hold a newer writer.
        waw = !hde_ff[s] || (hdst_ff[s][4:0] == ZERO_REG) ||
              (sb_age_ff[hdst_ff[s]] >=
               ilc_write_done(sb_cls_ff[hdst_ff[s]]));
        unit = !(is_mul(hcls_ff[s]) && mul_busy) &&
               !(is_div(hcls_ff[s]) && div_busy);
        // Store base and store data see different latencies.
        slot_ok = hv_ff[s] && waw && unit &&
                  src_ok(hsa_ff[s], hsae_ff[s], hcls_ff[s], 1'b0) &&
                  src_ok(hsb_ff[s], hsbe_ff[s], hcls_ff[s], st);
    endfunction : slot_ok

    // True when slot 1 may issue in the same cycle as slot 0.
    function automatic logic pair_ok();
        logic ra;
        logic rb;
        logic ww;
        logic hit0;
        hit0 = hde_ff[0] && (hdst_ff[0][4:0] != ZERO_REG);
        // A same-cycle dependency needs a zero latency.
        ra = !(hit0 && hsae_ff[1] && hsa_ff[1] == hdst_ff[0]) ||
             (ilc_latency(hcls_ff[0], hcls_ff[1], 1'b0) == LAT_ZERO);
        rb = !(hit0 && hsbe_ff[1] && hsb_ff[1] == hdst_ff[0]) ||
             (ilc_latency(hcls_ff[0], hcls_ff[1],
                          hcls_ff[1] == ILC_STORE_CLASS) == LAT_ZERO);
        ww = !(hit0 && hde_ff[1] && hdst_ff[1] == hdst_ff[0]) ||
             (ilc_write_done(hcls_ff[0]) == LAT_ZERO);
        pair_ok = quad_ff && ra && rb && ww &&
                  !(is_mul(hcls_ff[0]) && is_mul(hcls_ff[1])) &&
                  !(is_div(hcls_ff[0]) && is_div(hcls_ff[1]));
    endfunction : pair_ok

    // Issue decision. Slot 1 never passes slot 0, and when slot 0 was a
    // stalled consumer the writer in slot 1 can clear on the same cycle when pair_ok holds.
    always_comb begin
        iss[0] = slot_ok(0);
        iss[1] = slot_ok(1) && (!hv_ff[0] || (iss[0] && pair_ok()));
        accept = DEC_VALID && ready_ff;
    end

    // Start the unit timers; the older slot wins if both could start.
    always_comb begin
        unit_cls = (iss[0] && (is_mul(hcls_ff[0]) || is_div(hcls_ff[0])))
                   ? hcls_ff[0] : hcls_ff[1];
        mul_start = (iss[0] && is_mul(hcls_ff[0])) ||
                    (iss[1] && is_mul(hcls_ff[1]));
        div_start = (iss[0] && is_div(hcls_ff[0])) ||
                    (iss[1] && is_div(hcls_ff[1]));
        mul_gap = (unit_cls == ILC_INT_MUL_QUAD_CLASS) ?
                  GAP_MUL_Q : GAP_MUL_L;
        div_gap = (unit_cls == ILC_FLOAT_DIVIDE_D_CLASS) ?
                  GAP_FLOAT_DIVIDE_CLASS_D : GAP_FLOAT_DIVIDE_CLASS_S;
    end

    // Independent multiplies keep the shorter spacing here; dependent
    // ones are held longer by the scoreboard. A quad multiply issued beside an older divide gets the 19-cycle long-multiply gap.
    ilc_unit_timer #(.W(GAP_W)) u_mul_timer (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .start (mul_start),
        .len   (mul_gap),
        .busy  (mul_busy)
    );

    ilc_unit_timer #(.W(GAP_W)) u_div_timer (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .start (div_start),
        .len   (div_gap),
        .busy  (div_busy)
    );

    // Scoreboard next state: ages count up, issued writers restart them.
    // Impossible class pairs just get whatever the table yields.
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            nxt_cls[r] = sb_cls_ff[r];
            nxt_age[r] = sb_age_ff[r];
            // A missing load keeps its consumers waiting.
            if (!(LOAD_MISS_HOLD && sb_cls_ff[r] == ILC_LOAD_CLASS) &&
                sb_age_ff[r] != AGE_MAX) begin
                nxt_age[r] = sb_age_ff[r] + AGE_ONE;
            end
        end
        // Slot 1 is applied last so the younger write owns the entry.
        for (int s = 0; s < 2; s++) begin
            if (iss[s] && hde_ff[s] && hdst_ff[s][4:0] != ZERO_REG) begin
                nxt_cls[hdst_ff[s]] = hcls_ff[s];
                nxt_age[hdst_ff[s]] = AGE_ONE;
            end
        end
    end

    // Register the scoreboard.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                sb_cls_ff[r] <= ILC_NONE;
                sb_age_ff[r] <= AGE_MAX;
            end
        end else begin
            sb_cls_ff <= nxt_cls;
            sb_age_ff <= nxt_age;
        end
    end

    // Slots empty as they issue; a new pair loads only into an empty
    // stage, which costs one bubble per pair but keeps ready registered.
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            nxt_hv[s] = hv_ff[s] && !iss[s];
        end
        if (accept) begin
            nxt_hv[0] = DEC0_VALID;
            nxt_hv[1] = DEC1_VALID;
        end
        nxt_ready = !nxt_hv[0] && !nxt_hv[1];
    end

    // Register the held pair; operand fields load only on accept.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int s = 0; s < 2; s++) begin
                hv_ff[s]   <= 1'b0;
                hcls_ff[s] <= ILC_NONE;
                hdst_ff[s] <= '0;
                hde_ff[s]  <= 1'b0;
                hsa_ff[s]  <= '0;
                hsae_ff[s] <= 1'b0;
                hsb_ff[s]  <= '0;
                hsbe_ff[s] <= 1'b0;
            end
            quad_ff  <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            hv_ff    <= nxt_hv;
            ready_ff <= nxt_ready;
            if (accept) begin
                hcls_ff <= '{DEC0_CLASS, DEC1_CLASS};
                hdst_ff <= '{DEC0_DST, DEC1_DST};
                hde_ff  <= '{DEC0_DST_EN, DEC1_DST_EN};
                hsa_ff  <= '{DEC0_SRCA, DEC1_SRCA};
                hsae_ff <= '{DEC0_SRCA_EN, DEC1_SRCA_EN};
                hsb_ff  <= '{DEC0_SRCB, DEC1_SRCB};
                hsbe_ff <= '{DEC0_SRCB_EN, DEC1_SRCB_EN};
                quad_ff <= DEC_SAME_QUAD;
            end
        end
    end

    // Issue outputs. A frozen valid slot shows as the inserted no-op.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            iv0_ff   <= 1'b0;
            iv1_ff   <= 1'b0;
            ic0_ff   <= ILC_NONE;
            ic1_ff   <= ILC_NONE;
            id0_ff   <= '0;
            id1_ff   <= '0;
            stall_ff <= 1'b0;
        end else begin
            iv0_ff   <= iss[0];
            iv1_ff   <= iss[1];
            ic0_ff   <= hcls_ff[0];
            ic1_ff   <= hcls_ff[1];
            id0_ff   <= hdst_ff[0];
            id1_ff   <= hdst_ff[1];
            stall_ff <= (hv_ff[0] && !iss[0]) ||
                        (hv_ff[1] && !iss[1]);
        end
    end

    assign DEC_READY    = ready_ff;
    assign ISSUE0_VALID = iv0_ff;
    assign ISSUE1_VALID = iv1_ff;
    assign ISSUE0_CLASS = ic0_ff;
    assign ISSUE1_CLASS = ic1_ff;
    assign ISSUE0_DST   = id0_ff;
    assign ISSUE1_DST   = id1_ff;
    assign ISSUE_STALL  = stall_ff;

    // Checks on the issue decision.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_mul_go;
        mul_start && unit_cls == ILC_INT_MUL_LONG_CLASS;
    endsequence

    sequence s_unit_quiet;
        !mul_start [*8];
    endsequence

    chk_dual_same_quad: assert property (
        iss[0] && iss[1] && hv_ff[0] |-> quad_ff)
        else $error("Pair issued across quadwords.");

    chk_mul_spacing: assert property (
        s_mul_go |=> s_unit_quiet ##1 mul_busy)
        else $error("Multiply issued inside its spacing.");

    chk_div_spacing: assert property (
        div_start |=> (!div_start && div_busy) [*8])
        else $error("Divide issued inside its spacing.");

    chk_slot_order: assert property (
        iss[1] && hv_ff[0] |-> iss[0])
        else $error("Younger slot passed the older one.");

    chk_raw_latency: assert property (
        iss[0] && hsae_ff[0] && hsa_ff[0][4:0] != ZERO_REG |->
        sb_age_ff[hsa_ff[0]] >=
        ilc_latency(sb_cls_ff[hsa_ff[0]], hcls_ff[0], 1'b0))
        else $error("Consumer issued before its latency.");

    chk_waw_order: assert property (
        iss[1] && hde_ff[1] && hdst_ff[1][4:0] != ZERO_REG |->
        sb_age_ff[hdst_ff[1]] >= ilc_write_done(sb_cls_ff[hdst_ff[1]]))
        else $error("Writer passed a late write.");

    chk_issue_report: assert property (
        iss[0] |=> ISSUE0_VALID && ISSUE0_CLASS == $past(hcls_ff[0]))
        else $error("Issue report lost the class.");

    chk_stall_report: assert property (
        hv_ff[0] && !iss[0] |=> ISSUE_STALL && !ISSUE0_VALID)
        else $error("Frozen slot not reported.");

    chk_ready_empty: assert property (
        accept |=> !DEC_READY || (!hv_ff[0] && !hv_ff[1]))
        else $error("Ready while pair held.");

endmodule : ilc_issue_interlock

`default_nettype wire

/* bench/ilc_decode_model.sv */
// Decode stage model that offers one instruction pair at a time.
`default_nettype none

module ilc_decode_model
    import ilc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        ready,
    output logic             vld,
    output logic             qd,
    output logic             den1,
    output ilc_class_type    c0,
    output ilc_class_type    c1,
    output logic [REG_W-1:0] a0,
    output logic [REG_W-1:0] d0,
    output logic [REG_W-1:0] a1,
    output logic [REG_W-1:0] b1,
    output logic [REG_W-1:0] d1
);
    // Lines start quiet so nothing is offered while reset is applied.
    initial begin
        {vld, qd, den1, a0, d0, a1, b1, d1} = '0;
        {c0, c1} = {ILC_NONE, ILC_NONE};
    end

    // Holds the pair until it is taken, then inverts every field so that
    // a late look at stale decode data can never pass for a match.
    task automatic offer(input ilc_class_type p, c, input logic q, e,
                         input logic [REG_W-1:0] x, y, s, t, w);
        @(posedge clk);
        #1;
        {vld, qd, den1, c0, c1} = {1'b1, q, e, p, c};
        {a0, d0, a1, b1, d1} = {x, y, s, t, w};
        do @(posedge clk); while (ready !== 1'b1);
        #1;
        {vld, qd, den1} = {1'b0, ~q, ~e};
        {c0, c1} = {ilc_class_type'(~p), ilc_class_type'(~c)};
        {a0, d0, a1, b1, d1} = ~{x, y, s, t, w};
    endtask : offer
endmodule : ilc_decode_model

`default_nettype wire

/* bench/issue_latency_interlock_tb.sv */
// Self-checking bench measuring issue spacing inside one offered pair.
`default_nettype none

module issue_latency_interlock_tb
    import ilc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;                 // Core clock, 10 ns period.
    logic rst_n = 1'b0;               // Asynchronous reset, active low.
    logic vld, qd, den1, rdy, i0v, i1v;
    ilc_class_type c0, c1, i1c;
    logic [REG_W-1:0] a0, d0, a1, b1, d1;
    ilc_class_type exp_cls[$];        // Expected class of the later slot.
    logic [6:0] exp_gap[$];           // Expected cycles between the slots.
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int t0 = 0;
    integer seed = 80;
    logic miss = 1'b0;                // Load miss hold driven by a test.
    logic stl;                        // Stall report of the design.
    ilc_class_type i0c;               // Class reported for slot 0.
    ilc_class_type cur_p;             // Class offered in slot 0.
    logic [REG_W-1:0] i0d, i1d;       // Destinations reported.
    logic [REG_W-1:0] cur_a, cur_d;   // Destinations offered.
    int stalls = 0;                   // Stall cycles seen in one test.

    always #5 clk = ~clk;

    ilc_decode_model ilc_decode_model_inst (.clk(clk), .ready(rdy),
        .vld(vld), .qd(qd), .den1(den1), .c0(c0), .c1(c1), .a0(a0),
        .d0(d0), .a1(a1), .b1(b1), .d1(d1));

    // Slot 0's two sources share one line; the load miss hold is raised only by the test that passes h.
    ilc_issue_interlock ilc_issue_interlock_inst (.SYS_CLK(clk),
        .RST_N(rst_n), .DEC_VALID(vld), .DEC_SAME_QUAD(qd),
        .DEC0_VALID(vld), .DEC0_CLASS(c0), .DEC0_DST(d0),
        .DEC0_DST_EN(vld), .DEC0_SRCA(a0), .DEC0_SRCA_EN(vld),
        .DEC0_SRCB(a0), .DEC0_SRCB_EN(vld), .DEC1_VALID(vld),
        .DEC1_CLASS(c1), .DEC1_DST(d1), .DEC1_DST_EN(den1),
        .DEC1_SRCA(a1), .DEC1_SRCA_EN(vld), .DEC1_SRCB(b1),
        .DEC1_SRCB_EN(vld), .LOAD_MISS_HOLD(miss), .DEC_READY(rdy),
        .ISSUE0_VALID(i0v), .ISSUE0_CLASS(i0c), .ISSUE0_DST(i0d),
        .ISSUE1_VALID(i1v), .ISSUE1_CLASS(i1c), .ISSUE1_DST(i1d),
        .ISSUE_STALL(stl));

    task automatic check(input logic [6:0] seen, want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %0d, expected %0d", $time,
                     seen, want);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // Both pulses are registered, so sampling at the edge is race free.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (stl === 1'b1) begin
            stalls++;
        end
        if (i0v === 1'b1) begin
            t0 = cyc;
            check({3'h0, i0c}, {3'h0, cur_p});
            check({1'b0, i0d}, {1'b0, cur_a});
        end
        if (i1v === 1'b1) begin
            if (exp_gap.size() == 0) begin
                check(7'h01, 7'h00);
            end else begin
                check(7'(cyc - t0), exp_gap.pop_front());
                check({3'h0, i1c}, {3'h0, exp_cls.pop_front()});
                check({1'b0, i1d}, {1'b0, cur_d});
            end
        end
    end

    // Mode 0: data source, 1: first source, 2: independent, 3: same dst.
    // Register numbers stay below 28 so neither derived tag hits r31.
    task automatic run(input ilc_class_type p, c, input int m,
                       input logic f, q, input logic [6:0] g,
                       input int h = 0);
        logic [REG_W-1:0] a, b, d;
        a = {f, 5'(1 + {$random(seed)} % 27)};
        b = a ^ 6'h01;
        d = (m == 3) ? a : a ^ 6'h02;
        cur_p = p;
        cur_a = a;
        cur_d = d;
        stalls = 0;
        exp_gap.push_back(g);
        exp_cls.push_back(c);
        ilc_decode_model_inst.offer(p, c, q,
            !(c inside {ILC_STORE_CLASS, ILC_INT_COND_BRANCH_CLASS}),
            b, a, (m == 1) ? a : b, (m == 0) ? a : b, d);
        // Slot 0 issues at the edge after the accept; a miss then
        // freezes the load age for h edges.
        if (h > 0) begin
            @(posedge clk);
            #1 miss = 1'b1;
            repeat (h) @(posedge clk);
            #1 miss = 1'b0;
        end
        for (int i = 0; i < 200 && exp_gap.size() > 0; i++) @(posedge clk);
        // A later slot that never issued is a hang, not a pass.
        if (exp_gap.size() != 0) begin
            check(7'(exp_gap.size()), 7'h00);
            exp_gap.delete();
            exp_cls.delete();
        end
        // Longest pending write is 63 cycles; let the scoreboard drain.
        repeat (70) @(posedge clk);
        // The later slot waits once per cycle of its gap.
        check(7'(stalls), g);
        $display("test done: %0d then %0d", p, c);
    endtask : run

    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        run(ILC_INT_ADD_LOGIC_CLASS, ILC_STORE_CLASS, 0, 0, 1, 7'h00);
        run(ILC_INT_ADD_LOGIC_CLASS, ILC_STORE_CLASS, 0, 0, 0, 7'h01);
        run(ILC_INT_ADD_LOGIC_CLASS, ILC_SHIFT_CMOVE_CLASS,
            1, 0, 1, 7'h01);
        run(ILC_SHIFT_CMOVE_CLASS, ILC_INT_ADD_LOGIC_CLASS,
            1, 0, 1, 7'h02);
        run(ILC_INT_ADD_LOGIC_CLASS, ILC_STORE_CLASS, 1, 0, 1, 7'h02);
        run(ILC_SHIFT_CMOVE_CLASS, ILC_STORE_CLASS, 0, 0, 1, 7'h00);
        run(ILC_INT_COMPARE_CLASS, ILC_INT_COND_BRANCH_CLASS,
            1, 0, 1, 7'h01);
        run(ILC_LOAD_CLASS, ILC_LOAD_CLASS, 1, 0, 1, 7'h03);
        run(ILC_LOAD_CLASS, ILC_LOAD_CLASS, 1, 0, 1, 7'h08, 5);
        run(ILC_LOAD_CLASS, ILC_INT_ADD_LOGIC_CLASS,
            3, 0, 1, 7'h03);
        run(ILC_JUMP_CLASS, ILC_INT_ADD_LOGIC_CLASS, 1, 0, 1, 7'h03);
        run(ILC_INT_MUL_LONG_CLASS, ILC_INT_MUL_LONG_CLASS,
            1, 0, 1, 7'h15);
        run(ILC_INT_MUL_LONG_CLASS, ILC_INT_MUL_LONG_CLASS,
            2, 0, 1, 7'h13);
        run(ILC_INT_MUL_QUAD_CLASS, ILC_INT_MUL_QUAD_CLASS,
            1, 0, 1, 7'h17);
        run(ILC_INT_MUL_QUAD_CLASS, ILC_INT_MUL_QUAD_CLASS,
            2, 0, 1, 7'h15);
        run(ILC_FLOAT_OPERATE_CLASS, ILC_STORE_CLASS, 0, 1, 1, 7'h04);
        run(ILC_FLOAT_DIVIDE_S_CLASS, ILC_FLOAT_DIVIDE_S_CLASS,
            1, 1, 1, 7'h22);
        run(ILC_FLOAT_DIVIDE_S_CLASS, ILC_FLOAT_DIVIDE_S_CLASS,
            2, 1, 1, 7'h1E);
        run(ILC_FLOAT_DIVIDE_D_CLASS, ILC_FLOAT_DIVIDE_D_CLASS,
            1, 1, 1, 7'h3F);
        run(ILC_FLOAT_DIVIDE_D_CLASS, ILC_FLOAT_DIVIDE_D_CLASS,
            2, 1, 1, 7'h3B);
        summarize();
    end

    // Every test ends well inside 200 cycles; a hang is cut off here.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule : issue_latency_interlock_tb

`default_nettype wire
